// *** common/rfb_pkg.sv ***
// Package for the radio frame buffer block: widths, command codes, carriers.
// Assumes one baseband core per instance and a host interface already decoded.
//
// Operation
// - One transmit and one receive buffer, both host readable and writable, shared.
// - Transmit buffer holds 2047 octets; lowest address is sent first, ascending.
// - Receive buffer stores 2047 octets; first octet at lowest address, ascending.
// - First received octet stored only after rx frame start; length latched then.
// - Receive frame end raised only after all octets including checksum stored.
// - Buffers carry payload only; headers are never fetched from them.
// - First transmit buffer read happens after preamble; later reads arbitrary.
// - Transmit frame end raised only after every octet read and sent.
// - Transmit length is high and low length bytes joined; includes checksum.
// - Auto checksum replaces trailing octets; select chooses 16 or 32 bit.
// - Underrun flag set when host write pointer below core read pointer.
// - Underrun flag sticky; length low write clears it and write pointer to -1.
// - After underrun, auto checksum covers octets actually present.
// - Retransmit without rewrite allowed; underrun flag keeps prior value.
// - Fill level counts stored receive octets; cleared by receive command.
// - Fill level counts transmit octets read; cleared during preamble.
// - Fill level is 11 bits across low and high bytes.
// - Threshold 11 bits, captured on high write; interrupt when level exceeds it, raised on receive stores only.
// - Zero length receive frame raises no frame start event.
package rfb_pkg;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int MAX_OCTETS = 2047;
  localparam logic [ADDR_W-1:0] PTR_NONE = 11'h7FF;
  localparam logic [ADDR_W-1:0] LEN_ZERO = 11'h000;
  localparam logic [ADDR_W-1:0] LVL_ONE = 11'h001;
  localparam logic [ADDR_W-1:0] FCS16_OCTETS = 11'h002;
  localparam logic [ADDR_W-1:0] FCS32_OCTETS = 11'h004;
  localparam int LEN_HIGH_W = 3;
  localparam logic [2:0] CMD_NOP = 3'h0;
  localparam logic [2:0] CMD_RX = 3'h1;
  localparam logic [2:0] CMD_TX = 3'h2;
  localparam logic [2:0] PORT_LEN_LOW = 3'h0;
  localparam logic [2:0] PORT_LEN_HIGH = 3'h1;
  localparam logic [2:0] PORT_THR_LOW = 3'h2;
  localparam logic [2:0] PORT_THR_HIGH = 3'h3;

  typedef struct packed {
    logic wr;
    logic rd;
    logic sel_rx;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } rfb_host_t;

  typedef struct packed {
    logic wr;
    logic [2:0] sel;
    logic [DATA_W-1:0] data;
  } rfb_cfg_t;
endpackage

// *** hdl/rfb_mem.sv ***
// Dual-port octet store used for both the transmit and the receive buffer.
// Assumes port A and port B share one clock and clock enable; port B is the core side only in the transmit buffer.
`timescale 1ns/1ps
module rfb_mem #(
  parameter int AW = 11,
  parameter int DW = 8
) (
  input wire logic mclk,
  input wire logic ce,
  input wire logic a_we,
  input wire logic [AW-1:0] a_addr,
  input wire logic [DW-1:0] a_wdata,
  output logic [DW-1:0] a_rdata,
  input wire logic b_we,
  input wire logic [AW-1:0] b_addr,
  input wire logic [DW-1:0] b_wdata,
  output logic [DW-1:0] b_rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  initial
  begin
    if (AW < 2 || DW < 1)
      $error("rfb_mem: bad geometry");
  end

  // Port B write wins if both ports write in a cycle; the port A write is then dropped
  always_ff @(posedge mclk)
  begin
    if (ce)
    begin
      if (b_we)
        mem[b_addr] <= b_wdata;
      else if (a_we)
        mem[a_addr] <= a_wdata;
      a_rdata <= mem[a_addr];
      b_rdata <= mem[b_addr];
    end
  end
endmodule

// *** hdl/rfb_frame_buffer.sv ***
// Transmit and receive frame buffers of one baseband core with length,
// underrun, fill-level and level-threshold logic.
// Assumes host strobes and core strobes are on mclk; rx_sym_clk is a pin.
`timescale 1ns/1ps
module rfb_frame_buffer #(
  parameter int AW = rfb_pkg::ADDR_W
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire rfb_pkg::rfb_host_t host,
  output logic [rfb_pkg::DATA_W-1:0] host_rdata,
  input wire rfb_pkg::rfb_cfg_t cfg,
  input wire logic [2:0] radio_command,
  input wire logic auto_fcs_enable,
  input wire logic fcs_type_select,
  input wire logic preamble_done,
  input wire logic tx_octet_req,
  output logic [rfb_pkg::DATA_W-1:0] tx_octet,
  output logic tx_octet_valid,
  output logic tx_fcs_slot,
  input wire logic tx_sent,
  input wire logic rx_sym_clk,
  input wire logic rx_phr_valid,
  input wire logic [AW-1:0] rx_phr_length,
  input wire logic rx_octet_valid,
  input wire logic [rfb_pkg::DATA_W-1:0] rx_octet,
  output logic rx_frame_start_irq,
  output logic rx_frame_end_irq,
  output logic tx_frame_end_irq,
  output logic level_irq,
  output logic tx_underrun_flag,
  output logic [AW-1:0] tx_length,
  output logic [AW-1:0] rx_length,
  output logic [AW-1:0] buffer_fill_level,
  output logic [AW-1:0] level_irq_threshold,
  output logic rx_active
);
  initial
  begin
    if (AW != rfb_pkg::ADDR_W)
      $error("rfb_frame_buffer: address width must be 11");
  end

  typedef enum logic [1:0] {
    RFB_IDLE = 2'b00,
    RFB_PRE = 2'b01,
    RFB_PAY = 2'b10,
    RFB_DONE = 2'b11
  } rfb_tx_state_t;

  rfb_tx_state_t tx_state;
  logic [AW-1:0] host_write_pointer;
  logic [AW-1:0] core_read_pointer;
  logic [AW-1:0] rx_write_ptr;
  logic [rfb_pkg::DATA_W-1:0] thr_low_hold;
  logic [AW-1:0] fcs_octets;
  logic [AW-1:0] data_octets;
  logic [rfb_pkg::DATA_W-1:0] tx_mem_q;
  logic [rfb_pkg::DATA_W-1:0] rx_mem_q;
  logic [rfb_pkg::DATA_W-1:0] tx_host_q;
  logic sym_s1;
  logic sym_s2;
  logic sym_s3;
  logic sym_rise;
  logic rx_open;
  logic rx_store;
  logic tx_rd;
  logic tx_rd_d;
  logic tx_last;
  logic tx_host_we;
  logic rx_host_we;

  // The receive path is paced by the symbol clock pin, sampled twice first
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      sym_s1 <= 1'b0;
      sym_s2 <= 1'b0;
      sym_s3 <= 1'b0;
    end
    else if (ce)
    begin
      sym_s1 <= rx_sym_clk;
      sym_s2 <= sym_s1;
      sym_s3 <= sym_s2;
    end
  end
  assign sym_rise = sym_s2 && !sym_s3;

  assign tx_host_we = host.wr && !host.sel_rx;
  assign rx_host_we = host.wr && host.sel_rx;
  assign fcs_octets = fcs_type_select ? rfb_pkg::FCS32_OCTETS : rfb_pkg::FCS16_OCTETS;
  assign data_octets = (tx_length > fcs_octets) ? tx_length - fcs_octets : rfb_pkg::LEN_ZERO;
  assign tx_rd = (tx_state == RFB_PAY) && tx_octet_req && (core_read_pointer != tx_length);
  assign tx_last = (core_read_pointer == tx_length) && (tx_length != rfb_pkg::LEN_ZERO);
  assign rx_store = rx_open && rx_octet_valid && sym_rise && (rx_write_ptr != rx_length);

  // Payload only: the core addresses buffers from zero, no header octets
  rfb_mem #(.AW(AW), .DW(rfb_pkg::DATA_W)) u_tx_mem (
    .mclk(mclk),
    .ce(ce),
    .a_we(tx_host_we),
    .a_addr(host.addr),
    .a_wdata(host.wdata),
    .a_rdata(tx_host_q),
    .b_we(1'b0),
    .b_addr(core_read_pointer),
    .b_wdata(rfb_pkg::DATA_W'(0)),
    .b_rdata(tx_mem_q)
  );

  rfb_mem #(.AW(AW), .DW(rfb_pkg::DATA_W)) u_rx_mem (
    .mclk(mclk),
    .ce(ce),
    .a_we(rx_host_we || rx_store),
    .a_addr(rx_store ? rx_write_ptr : host.addr),
    .a_wdata(rx_store ? rx_octet : host.wdata),
    .a_rdata(rx_mem_q),
    .b_we(1'b0),
    .b_addr(host.addr),
    .b_wdata(rfb_pkg::DATA_W'(0)),
    .b_rdata()
  );

  // Host read data, registered one cycle after the read strobe
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      host_rdata <= '0;
    else if (ce)
    begin
      if (host.rd)
        host_rdata <= host.sel_rx ? rx_mem_q : tx_host_q;
    end
  end

  // Length and threshold configuration bytes
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      tx_length <= '0;
      thr_low_hold <= '0;
      level_irq_threshold <= '0;
    end
    else if (ce && cfg.wr)
    begin
      unique case (cfg.sel)
        rfb_pkg::PORT_LEN_LOW: tx_length[7:0] <= cfg.data;
        rfb_pkg::PORT_LEN_HIGH: tx_length[AW-1:8] <= cfg.data[rfb_pkg::LEN_HIGH_W-1:0];
        rfb_pkg::PORT_THR_LOW: thr_low_hold[7:0] <= cfg.data;
        rfb_pkg::PORT_THR_HIGH: level_irq_threshold <= {cfg.data[rfb_pkg::LEN_HIGH_W-1:0], thr_low_hold[7:0]};
        default: ;
      endcase
    end
  end

  // Host write pointer follows the last transmit buffer write
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      host_write_pointer <= rfb_pkg::PTR_NONE;
    else if (ce)
    begin
      if (cfg.wr && cfg.sel == rfb_pkg::PORT_LEN_LOW)
        host_write_pointer <= rfb_pkg::PTR_NONE;
      else if (tx_host_we)
        host_write_pointer <= host.addr;
    end
  end

  // Sticky underrun; set beats clear; -1 counts as below every address
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      tx_underrun_flag <= 1'b0;
    else if (ce)
    begin
      if (tx_rd && (host_write_pointer == rfb_pkg::PTR_NONE || host_write_pointer < core_read_pointer))
        tx_underrun_flag <= 1'b1;
      else if (cfg.wr && cfg.sel == rfb_pkg::PORT_LEN_LOW)
        tx_underrun_flag <= 1'b0;
    end
  end

  // Transmit sequencing: retransmit reuses buffer and lengths untouched
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      tx_state <= RFB_IDLE;
      core_read_pointer <= '0;
    end
    else if (ce)
    begin
      unique case (tx_state)
        RFB_IDLE:
        begin
          if (radio_command == rfb_pkg::CMD_TX)
          begin
            tx_state <= RFB_PRE;
            core_read_pointer <= '0;
          end
        end
        RFB_PRE:
        begin
          if (preamble_done)
            tx_state <= RFB_PAY;
        end
        RFB_PAY:
        begin
          if (tx_rd)
            core_read_pointer <= core_read_pointer + rfb_pkg::LVL_ONE;
          if (tx_last && tx_sent)
            tx_state <= RFB_DONE;
        end
        RFB_DONE:
          tx_state <= RFB_IDLE;
      endcase
    end
  end

  // Octet out; checksum slots flagged so the CRC engine substitutes them
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      tx_rd_d <= 1'b0;
      tx_octet_valid <= 1'b0;
      tx_octet <= '0;
      tx_fcs_slot <= 1'b0;
      tx_frame_end_irq <= 1'b0;
    end
    else if (ce)
    begin
      tx_rd_d <= tx_rd;
      tx_octet_valid <= tx_rd_d;
      if (tx_rd_d)
      begin
        tx_octet <= tx_mem_q;
        tx_fcs_slot <= auto_fcs_enable && (core_read_pointer > data_octets);
      end
      tx_frame_end_irq <= (tx_state == RFB_DONE);
    end
  end

  // Receive framing and write pointer
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rx_open <= 1'b0;
      rx_active <= 1'b0;
      rx_length <= '0;
      rx_write_ptr <= '0;
      rx_frame_start_irq <= 1'b0;
      rx_frame_end_irq <= 1'b0;
    end
    else if (ce)
    begin
      rx_frame_start_irq <= 1'b0;
      rx_frame_end_irq <= 1'b0;
      if (radio_command == rfb_pkg::CMD_RX)
      begin
        rx_active <= 1'b1;
        rx_open <= 1'b0;
        rx_write_ptr <= '0;
      end
      else if (rx_active && rx_phr_valid && !rx_open)
      begin
        rx_length <= rx_phr_length;
        rx_write_ptr <= '0;
        if (rx_phr_length != rfb_pkg::LEN_ZERO)
        begin
          rx_open <= 1'b1;
          rx_frame_start_irq <= 1'b1;
        end
      end
      else if (rx_store)
      begin
        rx_write_ptr <= rx_write_ptr + rfb_pkg::LVL_ONE;
        if (rx_write_ptr + rfb_pkg::LVL_ONE == rx_length)
        begin
          rx_open <= 1'b0;
          rx_active <= 1'b0;
          rx_frame_end_irq <= 1'b1;
        end
      end
    end
  end

  // Fill level gauge and threshold interrupt
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      buffer_fill_level <= '0;
      level_irq <= 1'b0;
    end
    else if (ce)
    begin
      level_irq <= 1'b0;
      if (radio_command == rfb_pkg::CMD_RX || tx_state == RFB_PRE)
        buffer_fill_level <= '0;
      else if (rx_store || tx_rd)
      begin
        buffer_fill_level <= buffer_fill_level + rfb_pkg::LVL_ONE;
        if (rx_store && buffer_fill_level + rfb_pkg::LVL_ONE > level_irq_threshold
            && !(buffer_fill_level > level_irq_threshold))
          level_irq <= 1'b1;
      end
    end
  end

  underrun_sticky_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (tx_underrun_flag && ce && !(cfg.wr && cfg.sel == rfb_pkg::PORT_LEN_LOW)) |=> tx_underrun_flag)
    else $error("underrun flag dropped without length write");
  underrun_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (ce && tx_rd && host_write_pointer < core_read_pointer) |=> tx_underrun_flag)
    else $error("underrun not flagged");
  wptr_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (ce && cfg.wr && cfg.sel == rfb_pkg::PORT_LEN_LOW) |=> host_write_pointer == rfb_pkg::PTR_NONE)
    else $error("write pointer not reset");
  first_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (ce && tx_state == RFB_PRE && !preamble_done) |=> !tx_rd)
    else $error("transmit read before preamble end");
  tx_end_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(tx_frame_end_irq) |-> $past(tx_last))
    else $error("transmit end before all octets read");
  rx_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
    rx_frame_start_irq |-> rx_length != rfb_pkg::LEN_ZERO)
    else $error("start event for empty frame");
  rx_end_a: assert property (@(posedge mclk) disable iff (sys_rst)
    rx_frame_end_irq |-> rx_write_ptr == rx_length)
    else $error("receive end before payload stored");
  rx_order_a: assert property (@(posedge mclk) disable iff (sys_rst)
    rx_store |-> rx_open)
    else $error("octet stored before frame start");
  level_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (ce && radio_command == rfb_pkg::CMD_RX) |=> buffer_fill_level == rfb_pkg::LEN_ZERO)
    else $error("fill level not cleared");
  level_irq_a: assert property (@(posedge mclk) disable iff (sys_rst)
    level_irq |-> buffer_fill_level > level_irq_threshold)
    else $error("level interrupt below threshold");

  tx_frame_c: cover property (@(posedge mclk) tx_frame_end_irq);
  rx_frame_c: cover property (@(posedge mclk) rx_frame_end_irq);
  underrun_c: cover property (@(posedge mclk) $rose(tx_underrun_flag));
  level_c: cover property (@(posedge mclk) level_irq);
endmodule

// *** tb/rfb_core_model.sv ***
// Baseband core stand-in: paces transmit reads and feeds received octets.
// Assumes it shares mclk with the buffer block and is steered by the bench.
`timescale 1ns/1ps
module rfb_core_model (
  input wire logic mclk,
  input wire logic [7:0] tx_octet,
  input wire logic tx_octet_valid,
  input wire logic tx_fcs_slot,
  output logic preamble_done,
  output logic tx_octet_req,
  output logic tx_sent,
  output logic rx_sym_clk,
  output logic rx_phr_valid,
  output logic [10:0] rx_phr_length,
  output logic rx_octet_valid,
  output logic [7:0] rx_octet
);
  logic [7:0] tx_seen[$];
  int n_slot = 0;
  initial
  begin
    preamble_done = 1'b0;
    tx_octet_req = 1'b0;
    tx_sent = 1'b0;
    rx_sym_clk = 1'b0;
    rx_phr_valid = 1'b0;
    rx_phr_length = 11'h000;
    rx_octet_valid = 1'b0;
    rx_octet = 8'h00;
  end
  always @(posedge mclk)
    if (tx_octet_valid === 1'b1)
    begin
      tx_seen.push_back(tx_octet);
      n_slot += (tx_fcs_slot === 1'b1);
    end
  // Preamble first, then reads; slow mode leaves gaps between requests
  task automatic run_tx(input int n, input bit slow);
    int k;
    k = 0;
    repeat (6) @(posedge mclk);
    #1 preamble_done = 1'b1;
    @(posedge mclk);
    #1 preamble_done = 1'b0;
    while (tx_seen.size() < n && k < 300)
    begin
      tx_octet_req = 1'b1;
      @(posedge mclk);
      #1 k++;
      if (slow)
      begin
        tx_octet_req = 1'b0;
        repeat (3) @(posedge mclk);
        #1;
      end
    end
    tx_octet_req = 1'b0;
    tx_sent = 1'b1;
    @(posedge mclk);
    #1 tx_sent = 1'b0;
  endtask
  // Symbol clock runs only while octets are offered; released lines are inverted
  task automatic send_rx(input logic [10:0] len, input logic [7:0] d[$]);
    @(posedge mclk);
    #1 rx_phr_length = len;
    rx_phr_valid = 1'b1;
    @(posedge mclk);
    #1 rx_phr_valid = 1'b0;
    rx_phr_length = ~len;
    foreach (d[i])
    begin
      rx_octet = d[i];
      rx_octet_valid = 1'b1;
      #40 rx_sym_clk = 1'b1;
      #40 rx_sym_clk = 1'b0;
    end
    #1 rx_octet_valid = 1'b0;
    rx_octet = ~rx_octet;
  endtask
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the frame buffer block.
// Assumes the core model in rfb_core_model.sv stands at the core side.
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  rfb_pkg::rfb_host_t host = '0;
  rfb_pkg::rfb_cfg_t cfg = '0;
  logic [2:0] radio_command = rfb_pkg::CMD_NOP;
  logic auto_fcs_enable = 1'b0;
  logic fcs_type_select = 1'b0;
  logic [7:0] host_rdata, tx_octet, rx_octet, rd;
  logic [10:0] tx_length, rx_length, buffer_fill_level, level_irq_threshold, rx_phr_length;
  logic tx_octet_valid, tx_fcs_slot, tx_sent, preamble_done, tx_octet_req, rx_sym_clk;
  logic rx_phr_valid, rx_octet_valid, rx_frame_start_irq, rx_frame_end_irq;
  logic tx_frame_end_irq, level_irq, tx_underrun_flag, rx_active;
  logic [7:0] q[$];
  int n_mismatch = 0;
  int n_tests = 0;
  int n_rfs = 0;
  int n_rfe = 0;
  int n_tfe = 0;
  int n_lvl = 0;
  always #5 mclk = ~mclk;
  rfb_frame_buffer dut (.mclk, .sys_rst, .ce(1'b1), .host, .host_rdata, .cfg, .radio_command,
    .auto_fcs_enable, .fcs_type_select, .preamble_done, .tx_octet_req, .tx_octet, .tx_octet_valid,
    .tx_fcs_slot, .tx_sent, .rx_sym_clk, .rx_phr_valid, .rx_phr_length, .rx_octet_valid, .rx_octet,
    .rx_frame_start_irq, .rx_frame_end_irq, .tx_frame_end_irq, .level_irq, .tx_underrun_flag,
    .tx_length, .rx_length, .buffer_fill_level, .level_irq_threshold, .rx_active);
  rfb_core_model core (.mclk, .tx_octet, .tx_octet_valid, .tx_fcs_slot, .preamble_done,
    .tx_octet_req, .tx_sent, .rx_sym_clk, .rx_phr_valid, .rx_phr_length, .rx_octet_valid, .rx_octet);
  always @(posedge mclk)
  begin
    n_rfs += (rx_frame_start_irq === 1'b1);
    n_rfe += (rx_frame_end_irq === 1'b1);
    n_tfe += (tx_frame_end_irq === 1'b1);
    n_lvl += (level_irq === 1'b1);
  end
  task automatic check(input string what, input logic [10:0] seen, input logic [10:0] want);
    n_tests++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic print_verdict;
    $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic host_wr(input logic rx, input logic [10:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1 host = '{1'b1, 1'b0, rx, a, d};
    @(posedge mclk);
    #1 host.wr = 1'b0;
  endtask
  // Address is held one cycle ahead of the read strobe
  task automatic host_rd(input logic rx, input logic [10:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1 host = '{1'b0, 1'b0, rx, a, 8'h00};
    @(posedge mclk);
    #1 host.rd = 1'b1;
    @(posedge mclk);
    #1 host.rd = 1'b0;
    d = host_rdata;
  endtask
  task automatic cfg_wr(input logic [2:0] s, input logic [7:0] d);
    @(posedge mclk);
    #1 cfg = '{1'b1, s, d};
    @(posedge mclk);
    #1 cfg.wr = 1'b0;
  endtask
  task automatic command(input logic [2:0] c);
    @(posedge mclk);
    #1 radio_command = c;
    @(posedge mclk);
    #1 radio_command = rfb_pkg::CMD_NOP;
  endtask
  // Length low first, then the first m payload octets
  task automatic load_tx(input logic [10:0] n, input int m);
    cfg_wr(rfb_pkg::PORT_LEN_LOW, n[7:0]);
    cfg_wr(rfb_pkg::PORT_LEN_HIGH, {5'h00, n[10:8]});
    for (int i = 0; i < m; i++)
      host_wr(1'b0, 11'(i), 8'h30 + 8'(i));
    repeat (2) @(posedge mclk);
    check("tx length", tx_length, n);
  endtask
  // Sends n octets and compares the first c; w octets are written from the preamble on, into the payload reads
  task automatic tx_frame(input int n, input int c, input bit slow, input int w = 0);
    int e;
    e = n_tfe;
    core.tx_seen.delete();
    core.n_slot = 0;
    command(rfb_pkg::CMD_TX);
    fork
      core.run_tx(n, slow);
      for (int i = 0; i < w; i++)
        host_wr(1'b0, 11'(i), 8'h30 + 8'(i));
    join
    repeat (6) @(posedge mclk);
    for (int i = 0; i < c; i++)
      check("tx octet", core.tx_seen[i], 8'h30 + 8'(i));
    check("tx octet count", 11'(core.tx_seen.size()), 11'(n));
    check("tx fill level", buffer_fill_level, 11'(n));
    check("tx frame end", 11'(n_tfe - e), 11'h001);
  endtask
  initial
  begin
    repeat (16) @(posedge mclk);
    #1 sys_rst = 1'b0;
    @(posedge mclk);
    check("underrun after reset", tx_underrun_flag, 1'b0);
    check("level after reset", buffer_fill_level, 11'h000);
    cfg_wr(rfb_pkg::PORT_THR_LOW, 8'h02);
    @(posedge mclk);
    check("threshold before high", level_irq_threshold, 11'h000);
    cfg_wr(rfb_pkg::PORT_THR_HIGH, 8'h00);
    @(posedge mclk);
    check("threshold", level_irq_threshold, 11'h002);
    load_tx(11'h7FF, 0);
    $display("test config done");
    load_tx(11'h006, 6);
    tx_frame(6, 6, 1'b0);
    check("underrun clean", tx_underrun_flag, 1'b0);
    for (int f = 0; f < 2; f++)
    begin
      auto_fcs_enable = 1'b1;
      fcs_type_select = f[0];
      tx_frame(6, 2, 1'b1);
      check("fcs slots", 11'(core.n_slot), f ? 11'h004 : 11'h002);
      check("underrun kept", tx_underrun_flag, 1'b0);
    end
    auto_fcs_enable = 1'b0;
    $display("test transmit done");
    load_tx(11'h006, 2);
    tx_frame(6, 6, 1'b0);
    check("underrun set", tx_underrun_flag, 1'b1);
    tx_frame(6, 6, 1'b1);
    check("underrun on resend", tx_underrun_flag, 1'b1);
    for (int i = 2; i < 6; i++)
      host_wr(1'b0, 11'(i), 8'h30 + 8'(i));
    check("underrun sticky", tx_underrun_flag, 1'b1);
    load_tx(11'h006, 0);
    check("underrun cleared", tx_underrun_flag, 1'b0);
    tx_frame(6, 6, 1'b0);
    check("underrun from -1", tx_underrun_flag, 1'b1);
    load_tx(11'h006, 0);
    tx_frame(6, 6, 1'b1, 6);
    check("underrun write ahead", tx_underrun_flag, 1'b0);
    $display("test underrun done");
    command(rfb_pkg::CMD_RX);
    @(posedge mclk);
    check("rx level cleared", buffer_fill_level, 11'h000);
    check("rx armed", rx_active, 1'b1);
    for (int i = 0; i < 4; i++)
      q.push_back(8'h51 + 8'(i));
    core.send_rx(11'h004, q);
    repeat (12) @(posedge mclk);
    check("rx length", rx_length, 11'h004);
    check("rx start", 11'(n_rfs), 11'h001);
    check("rx end", 11'(n_rfe), 11'h001);
    check("rx level", buffer_fill_level, 11'h004);
    check("level irq", 11'(n_lvl), 11'h001);
    for (int i = 0; i < 4; i++)
    begin
      host_rd(1'b1, 11'(i), rd);
      check("rx octet", rd, 8'h51 + 8'(i));
    end
    q.delete();
    command(rfb_pkg::CMD_RX);
    core.send_rx(11'h000, q);
    repeat (12) @(posedge mclk);
    check("zero length start", 11'(n_rfs), 11'h001);
    check("zero length", rx_length, 11'h000);
    $display("test receive done");
    print_verdict();
  end
  initial
  begin
    repeat (40000) @(posedge mclk);
    n_mismatch++;
    $display("Error watchdog expected done seen timeout");
    print_verdict();
  end
endmodule
